//--- verilog/vmon_consts.vh
// Purpose: shared constants of the supply voltage monitor control block
// Assumes: AXI4-Lite register bus with 32-bit data, one aligned word per register
// Notes: offsets are byte addresses
`ifndef VMON_CONSTS_VH
`define VMON_CONSTS_VH

// register byte offsets
`define VMON_OFF_CTRL 4'h0
`define VMON_OFF_FLAGS 4'h4
`define VMON_OFF_IRQEN 4'h8
`define VMON_OFF_GLOBAL 4'hC
`define VMON_ADDR_W 4

// control register fields
`define VMON_CTRL_DIR 7
`define VMON_CTRL_STABLE 5
`define VMON_CTRL_PWR 4
`define VMON_CTRL_LVL_HI 3
`define VMON_CTRL_LVL_LO 0
`define VMON_CTRL_WMASK 8'h9F
`define VMON_CTRL_RST 8'h05

// flag, enable and global register fields
`define VMON_FLAG_EVENT 2
`define VMON_GLOBAL_IRQ_EN 7
`define VMON_REG_RST 8'h00

// trip level codes
`define VMON_LVL_EXT 4'hF
`define VMON_LVL_RSVD 4'h0

// settle time in nanoseconds and clock period in nanoseconds
`define VMON_SETTLE_NS 20000
`define VMON_CLK_NS 4

// AXI responses
`define VMON_RESP_OKAY 2'h0
`define VMON_RESP_SLVERR 2'h2

`endif

//--- verilog/vmon_sync3.v
// Purpose: three-flop synchroniser with agreement filter for asynchronous levels
// Assumes: input is a slow level from outside the core_clk domain
// Notes: output changes only once the second and third stages agree
`timescale 1ns/100ps

module vmon_sync3 #(
  parameter RST_VAL = 1'b0
) (
  // clock and reset
  input wire core_clk,
  input wire sys_rst,
  // level in and filtered level out
  input wire async_in,
  output reg level_q
);

  reg s1_q;
  reg s2_q;
  reg s3_q;

  always @(posedge core_clk) begin
    if (sys_rst) begin
      s1_q <= RST_VAL;
      s2_q <= RST_VAL;
      s3_q <= RST_VAL;
      level_q <= RST_VAL;
    end else begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      // first stage read only by the second
      if (s2_q == s3_q) begin
        level_q <= s3_q;
      end
    end
  end

endmodule // vmon_sync3

//--- verilog/vmon_ctrl.v
// Purpose: control, flag and interrupt logic of a supply voltage trip monitor
// Assumes: analog comparator gives a level high while the selected input is at
//   or above the trip point; analog reference gives a level once settled
// Notes: registers are reached over AXI4-Lite, 8-bit data in low bits
// Operation
// - direction set: event at or above trip point; clear: below
// - control bit six reads zero and ignores writes
// - control bit five is read-only reference stable flag
// - control bit four powers the comparator and divider
// - trip level code 1111 selects external pin, 0000 reserved, others divider taps
// - stable flag held clear after each enable until settled; no event before
// - enabled monitor sets event flag when comparator finds supply at trip point
// - settle interval is a fixed time; crossings during it are missed
// - event flag is bit two of flag register two, cleared by software
// - interrupt request only when event enable and global enable both set
// - monitoring continues in sleep; event raises wake request when event enable is set
// - reset returns control to direction 0, off, level code 0101
//
// The register addresses and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/100ps

`include "vmon_consts.vh"

module vmon_ctrl #(
  parameter SETTLE_CYC = (`VMON_SETTLE_NS + `VMON_CLK_NS - 1) / `VMON_CLK_NS,
  parameter CNT_W = 16
) (
  // clock and reset
  input wire core_clk,
  input wire sys_rst,
  // AXI4-Lite write address and data
  input wire [`VMON_ADDR_W-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // AXI4-Lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read
  input wire [`VMON_ADDR_W-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // analog front end
  input wire comp_above,
  input wire ref_settled,
  output reg monitor_power_en,
  output reg [3:0] trip_level_sel,
  output reg ext_trip_input_sel,
  // processor side
  output reg irq,
  output reg wake_req
);

  localparam [CNT_W-1:0] SETTLE_MAX = SETTLE_CYC[CNT_W-1:0];
  // reset image split by field so no constant is cut silently
  localparam [7:0] CTRL_RST = `VMON_CTRL_RST;
  localparam [0:0] CTRL_RST_DIR = CTRL_RST[`VMON_CTRL_DIR];
  localparam [3:0] CTRL_RST_LVL = CTRL_RST[`VMON_CTRL_LVL_HI:`VMON_CTRL_LVL_LO];

  ////////////////////////////////////////////////////////////////////////////
  // registers

  reg trip_direction_sel_q;
  reg monitor_power_en_q;
  reg [3:0] trip_level_sel_q;
  reg reference_stable_flag_q;
  reg monitor_event_flag_q;
  reg monitor_event_irq_en_q;
  reg global_irq_en_q;
  reg [CNT_W-1:0] settle_cnt_q;
  reg [`VMON_ADDR_W-1:0] awaddr_q;
  reg [7:0] wdata_q;
  reg wstrb0_q;
  reg aw_held_q;
  reg w_held_q;

  wire comp_sync;
  wire ref_sync;

  // both analog levels come from outside the clock domain
  vmon_sync3 u_sync_comp (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .async_in(comp_above),
    .level_q(comp_sync)
  );

  vmon_sync3 u_sync_ref (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .async_in(ref_settled),
    .level_q(ref_sync)
  );

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function [7:0] ctrl_image;
    input dir;
    input stable;
    input pwr;
    input [3:0] lvl;
    begin
      ctrl_image = 8'h00;
      ctrl_image[`VMON_CTRL_DIR] = dir;
      ctrl_image[`VMON_CTRL_STABLE] = stable;
      ctrl_image[`VMON_CTRL_PWR] = pwr;
      ctrl_image[`VMON_CTRL_LVL_HI:`VMON_CTRL_LVL_LO] = lvl;
    end
  endfunction

  function addr_known;
    input [`VMON_ADDR_W-1:0] a;
    begin
      addr_known = (a == `VMON_OFF_CTRL) || (a == `VMON_OFF_FLAGS) ||
                   (a == `VMON_OFF_IRQEN) || (a == `VMON_OFF_GLOBAL);
    end
  endfunction

  // strobe of one register: whole write held and the low byte enabled
  function wr_hit;
    input go;
    input strb;
    input [`VMON_ADDR_W-1:0] a;
    input [`VMON_ADDR_W-1:0] off;
    begin
      wr_hit = go && strb && (a == off);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // write channel: address and data taken in either order

  // readies toggle while idle, so a held valid is taken within two cycles
  wire wr_go = aw_held_q && w_held_q && !s_axi_bvalid;
  wire wr_ctrl = wr_hit(wr_go, wstrb0_q, awaddr_q, `VMON_OFF_CTRL);
  wire wr_flags = wr_hit(wr_go, wstrb0_q, awaddr_q, `VMON_OFF_FLAGS);
  wire wr_irqen = wr_hit(wr_go, wstrb0_q, awaddr_q, `VMON_OFF_IRQEN);
  wire wr_global = wr_hit(wr_go, wstrb0_q, awaddr_q, `VMON_OFF_GLOBAL);

  always @(posedge core_clk) begin
    if (sys_rst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `VMON_RESP_OKAY;
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= {`VMON_ADDR_W{1'b0}};
      wdata_q <= 8'h00;
      wstrb0_q <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held_q && !s_axi_awready;
      s_axi_wready <= !w_held_q && !s_axi_wready;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q <= 1'b1;
        wdata_q <= s_axi_wdata[7:0];
        wstrb0_q <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= addr_known(awaddr_q) ? `VMON_RESP_OKAY : `VMON_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control register and settle timer

  always @(posedge core_clk) begin
    if (sys_rst) begin
      trip_direction_sel_q <= CTRL_RST_DIR;
      monitor_power_en_q <= 1'b0;
      trip_level_sel_q <= CTRL_RST_LVL;
      monitor_event_irq_en_q <= 1'b0;
      global_irq_en_q <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        // bits six and five are not writable
        trip_direction_sel_q <= wdata_q[`VMON_CTRL_DIR];
        monitor_power_en_q <= wdata_q[`VMON_CTRL_PWR];
        trip_level_sel_q <= wdata_q[`VMON_CTRL_LVL_HI:`VMON_CTRL_LVL_LO];
      end
      if (wr_irqen) begin
        monitor_event_irq_en_q <= wdata_q[`VMON_FLAG_EVENT];
      end
      if (wr_global) begin
        global_irq_en_q <= wdata_q[`VMON_GLOBAL_IRQ_EN];
      end
    end
  end

  // counter restarts on every enable; reference must also report settled
  // the count must outlast the three sync stages, or a settled level left
  // over from the last enable could set the flag early
  always @(posedge core_clk) begin
    if (sys_rst) begin
      settle_cnt_q <= {CNT_W{1'b0}};
      reference_stable_flag_q <= 1'b0;
    end else if (!monitor_power_en_q) begin
      settle_cnt_q <= {CNT_W{1'b0}};
      reference_stable_flag_q <= 1'b0;
    end else begin
      // saturates, so the flag holds while ref_sync stays high, until power is removed
      if (settle_cnt_q != SETTLE_MAX) begin
        settle_cnt_q <= settle_cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
      end
      reference_stable_flag_q <= (settle_cnt_q == SETTLE_MAX) && ref_sync;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // event detection and interrupt

  // limitation: the synced comparator lags a new level by five cycles, so changing
  // the level while powered can raise a false event
  // comparator output is high at or above trip point
  wire at_trip = trip_direction_sel_q ? comp_sync : !comp_sync;
  // reserved code never trips
  wire level_ok = trip_level_sel_q != `VMON_LVL_RSVD;
  wire trip_evt = monitor_power_en_q && reference_stable_flag_q && level_ok && at_trip;
  // write-one-to-clear; a new event in the same cycle wins
  wire evt_clr = wr_flags && wdata_q[`VMON_FLAG_EVENT];

  always @(posedge core_clk) begin
    if (sys_rst) begin
      monitor_event_flag_q <= 1'b0;
      irq <= 1'b0;
      wake_req <= 1'b0;
      monitor_power_en <= 1'b0;
      trip_level_sel <= CTRL_RST_LVL;
      ext_trip_input_sel <= 1'b0;
    end else begin
      if (trip_evt) begin
        monitor_event_flag_q <= 1'b1;
      end else if (evt_clr) begin
        monitor_event_flag_q <= 1'b0;
      end
      irq <= monitor_event_flag_q && monitor_event_irq_en_q && global_irq_en_q;
      // wake does not need the global enable
      wake_req <= monitor_event_flag_q && monitor_event_irq_en_q;
      // registered copies keep the analog controls glitch free
      monitor_power_en <= monitor_power_en_q;
      trip_level_sel <= trip_level_sel_q;
      ext_trip_input_sel <= trip_level_sel_q == `VMON_LVL_EXT;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read channel

  // decoded from the live address, which holds while arvalid waits
  reg [7:0] rd_byte;

  always @* begin
    rd_byte = 8'h00;
    case (s_axi_araddr)
      `VMON_OFF_CTRL: rd_byte = ctrl_image(trip_direction_sel_q, reference_stable_flag_q,
        monitor_power_en_q, trip_level_sel_q);
      `VMON_OFF_FLAGS: rd_byte[`VMON_FLAG_EVENT] = monitor_event_flag_q;
      `VMON_OFF_IRQEN: rd_byte[`VMON_FLAG_EVENT] = monitor_event_irq_en_q;
      `VMON_OFF_GLOBAL: rd_byte[`VMON_GLOBAL_IRQ_EN] = global_irq_en_q;
      default: rd_byte = 8'h00;
    endcase
  end

  always @(posedge core_clk) begin
    if (sys_rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `VMON_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h000000, rd_byte};
        s_axi_rresp <= addr_known(s_axi_araddr) ? `VMON_RESP_OKAY : `VMON_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule // vmon_ctrl

//--- tb/vmon_ctrl_monitor.sv
// Purpose: port checks of the monitor control block
// Assumes: one clock domain, synchronous reset
// Notes: bound to every vmon_ctrl
`timescale 1ns/100ps
module vmon_ctrl_monitor (
  // clock and reset
  input wire core_clk,
  input wire sys_rst,
  // bus handshakes
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  // analog control and processor side
  input wire monitor_power_en,
  input wire [3:0] trip_level_sel,
  input wire ext_trip_input_sel,
  input wire irq,
  input wire wake_req
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  a_irq_needs_wake: assert property (irq |-> wake_req)
    else $error("irq without wake");
  a_reset_state: assert property ($past(sys_rst) |-> !monitor_power_en &&
    trip_level_sel == 4'h5 && !irq) else $error("bad state after reset");
  a_ext_code: assert property (ext_trip_input_sel == (trip_level_sel == 4'hF))
    else $error("external select mismatch");
  a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped");
  a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("rvalid dropped");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready |-> ##[1:8] s_axi_bvalid)
    else $error("no write response");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("no read data");
  a_arready_pulse: assert property (s_axi_arready |=> !s_axi_arready)
    else $error("arready held");
  cover property ($rose(irq));
  cover property ($rose(wake_req) && !irq);
  cover property (ext_trip_input_sel && monitor_power_en);
endmodule // vmon_ctrl_monitor
////////////////////////////////////////////////////////////////////////////////
bind vmon_ctrl vmon_ctrl_monitor u_vmon_ctrl_monitor (.*);

//--- tb/vmon_analog_model.sv
// Purpose: behavioural comparator and reference of the monitor
// Assumes: supply given in tap units by the bench
// Notes: powered off, both outputs are low
`timescale 1ns/100ps
module vmon_analog_model #(
  parameter SETTLE_NS = 40
) (
  // control from the block
  input wire monitor_power_en,
  input wire [3:0] trip_level_sel,
  input wire ext_trip_input_sel,
  // conditions from the bench
  input wire [3:0] supply_tap,
  input wire ext_above,
  // analog results
  output wire comp_above,
  output wire ref_settled
);
  wire settled_dly;
  // reserved code has no tap, so it never reads above
  assign comp_above = monitor_power_en && (ext_trip_input_sel ? ext_above :
    trip_level_sel != 4'h0 && supply_tap >= trip_level_sel);
  // fixed analog delay, not counted in clocks; a shorter enable never settles
  assign #SETTLE_NS settled_dly = monitor_power_en;
  assign ref_settled = monitor_power_en && settled_dly;
endmodule // vmon_analog_model

//--- tb/tb.sv
// Purpose: self-checking bench of the monitor control block
// Assumes: settle count shortened to 8
// Notes: bus answers checked in order from a queue
`timescale 1ns/100ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("unexpected t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
  reg core_clk = 1'b0;
  reg sys_rst = 1'b1;
  reg [3:0] s_axi_awaddr = 4'h0;
  reg s_axi_awvalid = 1'b0;
  reg [31:0] s_axi_wdata = 32'h0;
  reg [3:0] s_axi_wstrb = 4'hF;
  reg s_axi_wvalid = 1'b0;
  reg s_axi_bready = 1'b0;
  reg [3:0] s_axi_araddr = 4'h0;
  reg s_axi_arvalid = 1'b0;
  reg s_axi_rready = 1'b0;
  reg [3:0] supply_tap = 4'h9;
  reg ext_above = 1'b0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire comp_above, ref_settled, monitor_power_en, ext_trip_input_sel, irq, wake_req;
  wire [3:0] trip_level_sel;
  int mismatches = 0;
  int n_checks = 0;
  logic [33:0] expq[$];
  logic [33:0] e;
  logic [31:0] seed = 32'd76092;
  vmon_ctrl #(.SETTLE_CYC(8)) u_vmon_ctrl (.*);
  vmon_analog_model u_vmon_analog_model (.*);
  initial forever #2 core_clk = ~core_clk;
  //////////////////////////////////////////////////////////////////////////////
  function automatic [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic wr(input [3:0] a, input [7:0] d, input [1:0] r);
    expq.push_back({r, 32'h0});
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    fork
      begin
        do @(posedge core_clk); while (!s_axi_awready);
        s_axi_awvalid <= 1'b0;
      end
      begin
        do @(posedge core_clk); while (!s_axi_wready);
        s_axi_wvalid <= 1'b0;
      end
    join
    do @(posedge core_clk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input [3:0] a, input [7:0] d, input [1:0] r);
    expq.push_back({r, 24'h0, d});
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge core_clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge core_clk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  always @(posedge core_clk) begin
    if (s_axi_bvalid && s_axi_bready) begin
      e = expq.pop_front();
      `CHK({s_axi_bresp, 32'h0}, e)
    end
    if (s_axi_rvalid && s_axi_rready) begin
      e = expq.pop_front();
      `CHK({s_axi_rresp, s_axi_rdata}, e)
    end
  end
  initial begin
    #20000;
    mismatches++;
    results;
  end
  initial begin
    repeat (8) @(posedge core_clk);
    sys_rst <= 1'b0;
    rd(4'h0, 8'h05, 2'h0);
    rd(4'h4, 8'h00, 2'h0);
    rd(4'h8, 8'h00, 2'h0);
    rd(4'h6, 8'h00, 2'h2);
    s_axi_wstrb <= 4'hE;
    wr(4'h0, 8'h9F, 2'h0);
    s_axi_wstrb <= 4'hF;
    wr(4'h6, 8'hFF, 2'h2);
    rd(4'h0, 8'h05, 2'h0);
    $display("end reset test");
    for (int i = 0; i < 6; i++) begin
      seed = lfsr(seed);
      wr(4'h0, 8'h00, 2'h0);
      wr(4'h0, seed[7:0], 2'h0);
      rd(4'h0, seed[7:0] & 8'h9F, 2'h0);
      `CHK({monitor_power_en, trip_level_sel}, seed[4:0])
    end
    $display("end register test");
    // setup order: off, level with direction clear, on, clear flag, enables
    wr(4'h0, 8'h00, 2'h0);
    wr(4'h0, 8'h05, 2'h0);
    wr(4'h0, 8'h15, 2'h0);
    wr(4'h4, 8'h04, 2'h0);
    wr(4'h8, 8'h04, 2'h0);
    wr(4'hC, 8'h80, 2'h0);
    repeat (30) @(posedge core_clk);
    rd(4'h0, 8'h35, 2'h0);
    `CHK(irq, 1'b0)
    supply_tap <= 4'h4;
    repeat (10) @(posedge core_clk);
    `CHK({irq, wake_req}, 2'b11)
    rd(4'h4, 8'h04, 2'h0);
    // clear while the trip condition persists: the set wins
    wr(4'h4, 8'h04, 2'h0);
    rd(4'h4, 8'h04, 2'h0);
    wr(4'hC, 8'h00, 2'h0);
    repeat (2) @(posedge core_clk);
    `CHK({irq, wake_req}, 2'b01)
    supply_tap <= 4'h9;
    repeat (8) @(posedge core_clk);
    wr(4'h4, 8'h04, 2'h0);
    rd(4'h4, 8'h00, 2'h0);
    $display("end low trip test");
    wr(4'h0, 8'h00, 2'h0);
    wr(4'h0, 8'h0F, 2'h0);
    wr(4'h0, 8'h8F, 2'h0);
    wr(4'h0, 8'h9F, 2'h0);
    // brief excursion inside the settle window must be lost
    ext_above <= 1'b1;
    repeat (3) @(posedge core_clk);
    ext_above <= 1'b0;
    repeat (30) @(posedge core_clk);
    rd(4'h4, 8'h00, 2'h0);
    ext_above <= 1'b1;
    repeat (10) @(posedge core_clk);
    rd(4'h4, 8'h04, 2'h0);
    `CHK(wake_req, 1'b1)
    $display("end external trip test");
    // reset in mid-run, with the monitor powered and the flag set
    sys_rst <= 1'b1;
    repeat (3) @(posedge core_clk);
    sys_rst <= 1'b0;
    rd(4'h0, 8'h05, 2'h0);
    rd(4'h4, 8'h00, 2'h0);
    `CHK({irq, wake_req, monitor_power_en, ext_trip_input_sel}, 4'h0)
    $display("end mid-run reset test");
    results;
  end
endmodule // tb
